//--- design/smr_pkg.sv
// Purpose: constants and types for the supply monitor and reset block
// Assumes: 10 MHz system clock, 8-bit register port
// Notes: reset sequencing for the core and the open-drain reset pin
// Operation
// - Hold core and reset pin low until battery supply passes power-on level
// - Add a power-on release delay after the power-on level is crossed
// - Power-on flag reads 1 on exit from power-on reset
// - Every reset other than power-on or power-fail clears power-on flag
// - Execution restarts from one fixed address whatever the reset cause
// - With battery monitor disabled any reset but power-fail becomes a full power-on reset
// - Power-on and power-fail resets enable and select the main monitor
// - Enabled, selected monitor holds reset while main supply is low
// - After power-fail reset the power-on flag reads 1
// - Only power-on and power-fail resets change monitor enable and select
// - Sleep suppresses power-fail reset; wake keeps software settings
// - Early-ok bit clears below warning level; interrupt when enabled
// - Flash erase or write with monitor disabled causes a reset
// - No power-on delay after a power-fail reset
// - Control register: enable, three status bits, two interrupt enables
// - Enabled monitor resets only when also selected
// - Status bit 6 reads 1 while main supply is above reset level
package smr_pkg;
    localparam int CLK_FREQ_MHZ = 10;
    localparam int T_POR_DELAY_US = 15000;
    localparam int RST_HOLD_CYC = 4;
    localparam logic [7:0] ADDR_SMC = 8'hFF;
    localparam logic [7:0] ADDR_RSR = 8'hEF;
    localparam logic [7:0] ADDR_PMR = 8'hEE;
    localparam int SMC_EN = 7;
    localparam int SMC_STAT = 6;
    localparam int SMC_EOK = 5;
    localparam int SMC_BOK = 4;
    localparam int SMC_MIE = 3;
    localparam int SMC_BIE = 2;
    localparam int RSR_POF = 1;
    localparam int PMR_BDIS = 5;
    localparam int SY_POR = 0;
    localparam int SY_RST = 1;
    localparam int SY_WARN = 2;
    localparam int SY_BAT = 3;
    localparam int SY_N = 4;
    localparam logic [15:0] BOOT_ADDR = 16'h0000;
    typedef enum logic [1:0] {
        SMR_POR = 2'h0,
        SMR_RUN = 2'h1,
        SMR_PF = 2'h3,
        SMR_HOLD = 2'h2
    } smr_state_t;
    typedef struct packed {
        logic bat_ok;
        logic warn_ok;
        logic rst_ok;
    } smr_cmp_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } smr_bus_t;
endpackage

//--- design/smr_top.sv
// Purpose: power-on and power-fail reset sequencer with monitor control
// Assumes: comparators are asynchronous levels; requests are on clk_sys
// Notes: power-fail release takes three cycles of latency, two of them in the synchroniser
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module smr_top #(
    parameter int POR_DLY_CYC = smr_pkg::T_POR_DELAY_US *
        smr_pkg::CLK_FREQ_MHZ
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Comparators
    input wire logic por_ok_i,
    input wire smr_pkg::smr_cmp_t cmp_i,
    // Core events
    input wire logic sleep_i,
    input wire logic sw_reset_i,
    input wire logic other_reset_i,
    input wire logic flash_op_i,
    // Register port
    input wire smr_pkg::smr_bus_t bus_i,
    output logic [7:0] rdata_q,
    // Reset outputs
    output logic core_reset_q,
    output logic rst_pin_q,
    output logic rst_pin_oe_q,
    output logic [15:0] boot_addr_q,
    // Analog controls and interrupt
    output logic mon_enable_q,
    output logic bat_mon_on_q,
    output logic warn_irq_q
);
    import smr_pkg::*;

    localparam int CNT_W = $clog2(POR_DLY_CYC + 1);
    localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_DLY_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(RST_HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    typedef struct packed {
        smr_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [SY_N-1:0] s1;
        logic [SY_N-1:0] s2;
        logic en;
        logic sel;
        logic pof;
        logic bdis;
        logic mie;
        logic bie;
        logic [7:0] rdata;
        logic core_rst;
        logic pin;
        logic pin_oe;
        logic [15:0] boot;
        logic mon_en;
        logic irq;
    } smr_regs_t;

    localparam smr_regs_t REGS_RST = '{
        st: SMR_POR,
        cnt: '0,
        s1: '0,
        s2: '0,
        en: 1'b1,
        sel: 1'b1,
        pof: 1'b1,
        bdis: 1'b0,
        mie: 1'b1,
        bie: 1'b0,
        rdata: 8'h00,
        core_rst: 1'b1,
        pin: 1'b0,
        pin_oe: 1'b1,
        boot: BOOT_ADDR,
        mon_en: 1'b1,
        irq: 1'b0
    };

    smr_regs_t q;
    smr_regs_t d;
    logic arst;
    logic pf_cond;
    logic other_req;

    // Supply loss asserts reset at once; release waits for the sync chain
    assign arst = rst | ~por_ok_i;

    // Sleep masks the power-fail path; stored settings stay untouched
    assign pf_cond = q.en && q.sel && !sleep_i &&
        !q.s2[SY_RST];
    assign other_req = sw_reset_i || other_reset_i ||
        (flash_op_i && !q.en);

    always_comb begin
        d = q;
        d.rdata = 8'h00;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                ADDR_SMC: begin
                    d.rdata[SMC_EN] = q.en;
                    d.rdata[SMC_STAT] = q.s2[SY_RST];
                    d.rdata[SMC_EOK] = q.s2[SY_WARN];
                    d.rdata[SMC_BOK] = q.s2[SY_BAT];
                    d.rdata[SMC_MIE] = q.mie;
                    d.rdata[SMC_BIE] = q.bie;
                end
                ADDR_RSR: d.rdata[RSR_POF] = q.pof;
                ADDR_PMR: d.rdata[PMR_BDIS] = q.bdis;
                default: d.rdata = 8'h00;
            endcase
        end
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                ADDR_SMC: begin
                    d.en = bus_i.wdata[SMC_EN];
                    d.mie = bus_i.wdata[SMC_MIE];
                    d.bie = bus_i.wdata[SMC_BIE];
                end
                // The flag bit doubles as the monitor reset select
                ADDR_RSR: d.sel = bus_i.wdata[RSR_POF];
                ADDR_PMR: d.bdis = bus_i.wdata[PMR_BDIS];
                default: d.en = q.en;
            endcase
        end
        unique case (q.st)
            SMR_POR: begin
                // Count only once the battery level is seen above threshold
                if (!q.s2[SY_POR]) begin
                    d.cnt = '0;
                end else if (q.cnt == POR_LAST) begin
                    d.st = SMR_RUN;
                    d.cnt = '0;
                    d.pof = 1'b1;
                end else begin
                    d.cnt = q.cnt + CNT_ONE;
                end
            end
            SMR_RUN: begin
                if (pf_cond) begin
                    d.st = SMR_PF;
                end else if (other_req && q.bdis) begin
                    d = REGS_RST;
                end else if (other_req) begin
                    d.st = SMR_HOLD;
                    d.cnt = '0;
                    d.pof = 1'b0;
                end
            end
            SMR_PF: begin
                // Release directly on recovery, no power-on delay
                if (q.s2[SY_RST]) begin
                    d.st = SMR_RUN;
                    d.en = 1'b1;
                    d.sel = 1'b1;
                    d.pof = 1'b1;
                end
            end
            SMR_HOLD: begin
                // Settings written by software survive this reset
                if (q.cnt == HOLD_LAST) begin
                    d.st = SMR_RUN;
                end else begin
                    d.cnt = q.cnt + CNT_ONE;
                end
            end
        endcase
        // Sync chain is never reloaded by a full power-on request
        d.s1 = {cmp_i.bat_ok, cmp_i.warn_ok, cmp_i.rst_ok, por_ok_i};
        d.s2 = q.s1;
        d.core_rst = d.st != SMR_RUN;
        d.pin_oe = d.st == SMR_POR || d.st == SMR_PF;
        d.pin = 1'b0;
        d.boot = BOOT_ADDR;
        d.mon_en = d.en && !sleep_i;
        d.irq = (d.mie && !q.s2[SY_WARN]) ||
            (d.bie && !q.s2[SY_BAT]);
    end

    always_ff @(posedge clk_sys or posedge arst) begin
        if (arst) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    assign rdata_q = q.rdata;
    assign core_reset_q = q.core_rst;
    assign rst_pin_q = q.pin;
    assign rst_pin_oe_q = q.pin_oe;
    assign boot_addr_q = q.boot;
    assign mon_enable_q = q.mon_en;
    assign bat_mon_on_q = !q.bdis;
    assign warn_irq_q = q.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (arst);

    por_hold_a: assert property (
        q.st == SMR_POR |-> core_reset_q && rst_pin_oe_q)
        else $error("core not held during power-on");
    por_delay_a: assert property (
        $past(q.st) == SMR_POR && q.st == SMR_RUN |->
        $past(q.cnt) == POR_LAST)
        else $error("power-on delay length wrong");
    por_flag_a: assert property (
        $fell(core_reset_q) && $past(q.st) == SMR_POR |-> q.pof)
        else $error("flag not set after power-on");
    other_clr_a: assert property (
        q.st == SMR_RUN && other_req && !pf_cond && !q.bdis |=>
        q.st == SMR_HOLD && !q.pof)
        else $error("other reset kept the flag");
    boot_addr_a: assert property (
        $fell(core_reset_q) |-> boot_addr_q == BOOT_ADDR)
        else $error("restart address wrong");
    full_por_a: assert property (
        q.st == SMR_RUN && other_req && !pf_cond && q.bdis |=>
        q.st == SMR_POR && bat_mon_on_q && q.cnt == '0)
        else $error("disabled monitor did not force power-on");
    pf_restore_a: assert property (
        $past(q.st) == SMR_PF && q.st == SMR_RUN |->
        q.en && q.sel && q.pof && !core_reset_q)
        else $error("power-fail exit state wrong");
    pf_enter_a: assert property (
        q.st == SMR_RUN && pf_cond |=> core_reset_q && rst_pin_oe_q)
        else $error("low supply did not reset");
    keep_cfg_a: assert property (
        q.st == SMR_HOLD && !bus_i.wr |=> $stable(q.en) && $stable(q.sel))
        else $error("other reset changed monitor settings");
    sleep_mask_a: assert property (
        q.st == SMR_RUN && sleep_i && !other_req |=> q.st == SMR_RUN)
        else $error("power-fail not masked in sleep");
    warn_irq_a: assert property (
        q.mie && !q.s2[SY_WARN] && !bus_i.wr |=> warn_irq_q)
        else $error("warning interrupt missing");
    flash_err_a: assert property (
        q.st == SMR_RUN && flash_op_i && !q.en |=> core_reset_q)
        else $error("flash error reset missing");
    pf_nodelay_a: assert property (
        q.st == SMR_PF && q.s2[SY_RST] |=> !core_reset_q)
        else $error("power-fail release delayed");

    por_idle_a: assert property (
        q.st == SMR_POR && !q.s2[SY_POR] |=> q.cnt == '0)
        else $error("power-on delay counted too early");

    pin_drive_a: assert property (
        rst_pin_oe_q |-> core_reset_q && !rst_pin_q)
        else $error("pin driven while core runs");

    hold_flag_a: assert property (
        q.st == SMR_HOLD |-> !q.pof && core_reset_q)
        else $error("flag set during other reset");

    hold_pin_a: assert property (
        q.st == SMR_HOLD |-> !rst_pin_oe_q)
        else $error("pin driven during other reset");

    boot_const_a: assert property (
        boot_addr_q == BOOT_ADDR)
        else $error("restart address moved");

    pmr_write_a: assert property (
        bus_i.wr && bus_i.addr == ADDR_PMR && !other_req |=>
        bat_mon_on_q != $past(bus_i.wdata[PMR_BDIS]))
        else $error("battery monitor control wrong");

    pf_hold_a: assert property (
        q.st == SMR_PF |-> core_reset_q && rst_pin_oe_q)
        else $error("power-fail reset not held");

    pf_stays_a: assert property (
        q.st == SMR_PF && !q.s2[SY_RST] |=> q.st == SMR_PF)
        else $error("power-fail left while supply low");

    mon_sleep_a: assert property (
        sleep_i |=> !mon_enable_q)
        else $error("monitor left on in sleep");

    irq_off_a: assert property (
        !q.mie && !q.bie && !bus_i.wr && !other_req |=> !warn_irq_q)
        else $error("interrupt raised while disabled");

    sel_write_a: assert property (
        bus_i.wr && bus_i.addr == ADDR_RSR && q.st != SMR_PF &&
        !other_req |=> q.sel == $past(bus_i.wdata[RSR_POF]))
        else $error("reset select write lost");

    en_write_a: assert property (
        bus_i.wr && bus_i.addr == ADDR_SMC && q.st != SMR_PF &&
        !other_req |=> q.en == $past(bus_i.wdata[SMC_EN]))
        else $error("monitor enable write lost");

    rdata_idle_a: assert property (
        !$past(bus_i.rd) |-> rdata_q == 8'h00)
        else $error("read data stands too long");

    stat_read_a: assert property (
        bus_i.rd && bus_i.addr == ADDR_SMC |=>
        rdata_q[SMC_STAT] == $past(q.s2[SY_RST]))
        else $error("supply status read wrong");

    run_free_a: assert property (
        q.st == SMR_RUN |-> !core_reset_q)
        else $error("core held while running");

    sel_only_a: assert property (
        q.st == SMR_RUN && !q.sel && !other_req |=> q.st == SMR_RUN)
        else $error("deselected monitor caused reset");
endmodule

//--- verification/smr_core_model.sv
// Purpose: core and reset pin as seen from outside the sequencer
// Assumes: the pin has a pull-up, so a released pin reads high
// Notes: the start address is taken while the core is held
`timescale 1ns/1ps
module smr_core_model (
    // Reset side
    input wire logic clk_sys,
    input wire logic core_reset,
    input wire logic pin_oe,
    input wire logic pin_val,
    input wire logic [15:0] boot_addr,
    // Observed
    output logic rst_pin_n,
    output logic [15:0] start_pc
);
    assign rst_pin_n = pin_oe ? pin_val : 1'b1;
    always_ff @(posedge clk_sys) begin
        if (core_reset) begin
            start_pc <= boot_addr;
        end
    end
endmodule

//--- verification/smr_top_tb_top.sv
// Purpose: self-checking bench for the supply monitor reset block
// Assumes: release delay shortened to DLY cycles
// Notes: random control values, fixed seed
`timescale 1ns/1ps
module smr_top_tb_top;
    import smr_pkg::*;
    localparam int DLY = 20;
    logic clk_sys = 0, rst = 1, por_ok_i = 0, sleep_i = 0;
    logic sw_reset_i = 0, other_reset_i = 0, flash_op_i = 0;
    smr_cmp_t cmp_i = 3'h7;
    smr_bus_t bus_i = '0;
    logic [7:0] rdata_q, d, v;
    logic core_reset_q, rst_pin_q, rst_pin_oe_q, mon_enable_q;
    logic bat_mon_on_q, warn_irq_q, rst_pin_n;
    logic [15:0] boot_addr_q, start_pc;
    int bad_count = 0, n_tests = 0, k;
    always #50 clk_sys = ~clk_sys;
    smr_top #(.POR_DLY_CYC(DLY)) uut (.clk_sys(clk_sys), .rst(rst),
        .por_ok_i(por_ok_i), .cmp_i(cmp_i), .sleep_i(sleep_i),
        .sw_reset_i(sw_reset_i), .other_reset_i(other_reset_i),
        .flash_op_i(flash_op_i), .bus_i(bus_i), .rdata_q(rdata_q),
        .core_reset_q(core_reset_q), .rst_pin_q(rst_pin_q),
        .rst_pin_oe_q(rst_pin_oe_q), .boot_addr_q(boot_addr_q),
        .mon_enable_q(mon_enable_q), .bat_mon_on_q(bat_mon_on_q),
        .warn_irq_q(warn_irq_q));
    smr_core_model core (.clk_sys(clk_sys), .core_reset(core_reset_q),
        .pin_oe(rst_pin_oe_q), .pin_val(rst_pin_q),
        .boot_addr(boot_addr_q), .rst_pin_n(rst_pin_n),
        .start_pc(start_pc));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk_sys);
        bus_i <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_i.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_i.rd <= 1'b0;
        #1 d = rdata_q;
    endtask
    // Counts edges until the core is let go; a hang ends the run
    task automatic wait_rel;
        k = 0;
        while (core_reset_q !== 1'b0 && k < 200) begin
            cyc(1);
            k++;
        end
        if (k >= 200) begin
            bad_count++;
            disable tests;
        end
        cyc(1);
        chk(start_pc, 16'h0000);
    endtask
    task automatic pulse(input int w);
        @(posedge clk_sys);
        sw_reset_i <= (w == 0);
        other_reset_i <= (w == 1);
        flash_op_i <= (w == 2);
        cyc(1);
        {sw_reset_i, other_reset_i, flash_op_i} <= 3'h0;
    endtask
    task automatic por_release;
        wait_rel();
        chk(k >= DLY && k <= DLY + 4, 1);
        rd(ADDR_SMC);
        chk(d, 8'hF8);
        rd(ADDR_RSR);
        chk(d[RSR_POF], 1);
    endtask
    initial begin
        begin : tests
        void'($urandom(32'h0927));
        cyc(4);
        rst <= 1'b0;
        cyc(10);
        chk({core_reset_q, rst_pin_n}, 2'b10);
        por_ok_i <= 1'b1;
        por_release();
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            wr(ADDR_SMC, v | 8'h80);
            rd(ADDR_SMC);
            chk(d, (v & 8'h0C) | 8'hF0);
        end
        rd(8'h10);
        chk(d, 8'h00);
        wr(ADDR_SMC, 8'h88);
        cmp_i.warn_ok <= 1'b0;
        cyc(4);
        chk(warn_irq_q, 1);
        rd(ADDR_SMC);
        chk(d[SMC_EOK], 0);
        wr(ADDR_SMC, 8'h84);
        cyc(2);
        chk(warn_irq_q, 0);
        cmp_i <= 3'h3;
        cyc(4);
        chk(warn_irq_q, 1);
        cmp_i <= 3'h7;
        wr(ADDR_SMC, 8'h88);
        sleep_i <= 1'b1;
        cmp_i.rst_ok <= 1'b0;
        cyc(6);
        chk({core_reset_q, mon_enable_q}, 2'b00);
        rd(ADDR_SMC);
        chk(d[SMC_STAT], 0);
        cmp_i.rst_ok <= 1'b1;
        sleep_i <= 1'b0;
        cyc(3);
        chk(mon_enable_q, 1);
        cmp_i.rst_ok <= 1'b0;
        cyc(3);
        chk({core_reset_q, rst_pin_n}, 2'b10);
        cmp_i.rst_ok <= 1'b1;
        wait_rel();
        chk(k, 3);
        rd(ADDR_RSR);
        chk(d[RSR_POF], 1);
        // Monitor off and deselected by software, then every request kind
        wr(ADDR_SMC, 8'h08);
        wr(ADDR_RSR, 8'h00);
        for (int w = 0; w < 3; w++) begin
            pulse(w);
            chk({core_reset_q, rst_pin_n}, 2'b11);
            wait_rel();
            chk(k, RST_HOLD_CYC);
            rd(ADDR_RSR);
            chk(d[RSR_POF], 0);
            rd(ADDR_SMC);
            chk(d[SMC_EN], 0);
        end
        wr(ADDR_SMC, 8'h88);
        pulse(2);
        chk(core_reset_q, 0);
        cmp_i.rst_ok <= 1'b0;
        cyc(5);
        chk(core_reset_q, 0);
        cmp_i.rst_ok <= 1'b1;
        wr(ADDR_RSR, 8'h02);
        wr(ADDR_SMC, 8'h08);
        wr(ADDR_PMR, 8'h20);
        cyc(2);
        chk(bat_mon_on_q, 0);
        pulse(0);
        chk({core_reset_q, rst_pin_n}, 2'b10);
        por_release();
        chk(bat_mon_on_q, 1);
        @(posedge clk_sys);
        por_ok_i <= 1'b0;
        #1 chk(core_reset_q, 1);
        cyc(2);
        por_ok_i <= 1'b1;
        por_release();
        end
        print_verdict();
    end
endmodule
